// ### logic/clockgen_cfg.svh
`ifndef CLOCKGEN_CFG_SVH
`define CLOCKGEN_CFG_SVH

// Register offsets (3-bit address)
`define CG_OFS_LOOP      3'h0
`define CG_OFS_BANDWIDTH 3'h1
`define CG_OFS_BRK_CTRL  3'h2
`define CG_OFS_CONFIG    3'h3
`define CG_OFS_IRQ_STAT  3'h4
`define CG_OFS_IRQ_CLR   3'h5
`define CG_OFS_IRQ_EN    3'h6

// loop_control_reg fields
`define CG_LOOP_IE_BIT   7
`define CG_LOOP_FLAG_BIT 6
`define CG_LOOP_ON_BIT   5
`define CG_LOOP_BCS_BIT  4

// Bandwidth register fields
`define CG_BW_AUTO_BIT   7
`define CG_BW_LOCK_BIT   6

// break_flag_ctrl_reg and config fields
`define CG_BRK_BREAK_CLEAR_ENABLE_BIT  7
`define CG_CFG_OSC_BIT   1

// Event bits of the interrupt status register
`define CG_EV_STOP_IN    0
`define CG_EV_STOP_OUT   1
`define CG_EV_LOCK       2
`define CG_EV_WIDTH      3

// Reset values
`define CG_RST_BREAK_CLEAR_ENABLE      1'b0
`define CG_RST_OSC_RUN   1'b0
`define CG_RST_IRQ_EN    3'h0

`endif

// ### logic/clockgen_pkg.sv
package clockgen_pkg;

  typedef enum logic {
    MODE_RUN,
    MODE_STOP
  } clk_mode_e;

  typedef struct packed {
    clk_mode_e  mode;
    logic       base_clock_select;
    logic       loop_irq_en;
    logic       loop_on;
    logic       auto_bw;
    logic       break_clear_enable;
    logic       osc_run_in_stop;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic       lock_q;
    logic       xtal_q;
    logic       vco_q;
    logic       bus_clk;
    logic       xtal_out;
    logic       clockgen_irq;
    logic       osc_en;
    logic       loop_en;
    logic       irq;
  } ctrl_state_s;

endpackage

// ### logic/sticky_flag.sv
module sticky_flag
  import clockgen_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             sys_clk_in,  // System clock
  input  wire logic             sys_rst_in,  // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] set_in,      // Per-bit set pulse
  input  wire logic [WIDTH-1:0] clear_in,    // Per-bit clear pulse
  output logic      [WIDTH-1:0] flag_out     // Sticky flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } flag_state_s;

  flag_state_s flag_reg;
  flag_state_s flag_next;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    flag_next      = flag_reg;
    flag_next.flag = (flag_reg.flag & ~clear_in) | set_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      flag_reg <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg.flag;

endmodule

// ### logic/clockgen_stop_break_control.sv
// Design decisions made here: the register offsets and the strobed register port.
`include "clockgen_cfg.svh"

module clockgen_stop_break_control
  import clockgen_pkg::*;
(
  input  wire logic       sys_clk_in,        // System clock, 125 MHz
  input  wire logic       sys_rst_in,        // Synchronous reset, active high
  input  wire logic [2:0] addr_in,           // Register address
  input  wire logic [7:0] wdata_in,          // Write data
  input  wire logic       wr_in,             // Write strobe
  input  wire logic       rd_in,             // Read strobe
  output logic      [7:0] rdata_out,         // Read data, cycle after strobe
  input  wire logic       stop_req_in,       // High while stop mode is requested
  input  wire logic       break_in,          // High during break state
  input  wire logic       lock_in,           // Loop lock indicator
  input  wire logic       crystal_clock_in,  // Sampled oscillator level
  input  wire logic       vco_clock_in,      // Sampled VCO level
  output logic            crystal_clock_out, // Gated crystal clock
  output logic            bus_clock_out,     // Halved selected clock
  output logic            clockgen_irq_out,  // Loop interrupt to CPU
  output logic            osc_enable_out,    // Oscillator power enable
  output logic            loop_enable_out,   // Loop power enable
  output logic            irq_out            // Event interrupt, level
);

  ctrl_state_s state_reg;
  ctrl_state_s state_next;

  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [2:0] ev_flags;
  logic       lock_set;
  logic       lock_clr;
  logic       lock_flag;
  logic       in_stop;
  logic       osc_alive;
  logic       protect;
  logic       xtal_rise;
  logic       vco_rise;
  logic       src_rise;
  logic       stop_entry;
  logic       stop_exit;
  logic       loop_rd;

  // Per-event status flags
  sticky_flag #(
    .WIDTH (`CG_EV_WIDTH)
  ) u_event_flags (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .set_in     (ev_set),
    .clear_in   (ev_clr),
    .flag_out   (ev_flags)
  );

  // Lock-change flag
  sticky_flag #(
    .WIDTH (1)
  ) u_lock_flag (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .set_in     (lock_set),
    .clear_in   (lock_clr),
    .flag_out   (lock_flag)
  );

  always_comb
  begin
    state_next       = state_reg;
    state_next.rdata = 8'h00;

    in_stop    = (state_reg.mode == MODE_STOP);
    osc_alive  = !in_stop || state_reg.osc_run_in_stop;
    stop_entry = 1'b0;
    stop_exit  = 1'b0;

    // Inputs are synchronous; no resynchronising stage
    case (state_reg.mode)
      MODE_RUN:
      begin
        if (stop_req_in)
        begin
          state_next.mode              = MODE_STOP;
          state_next.base_clock_select = 1'b0;
          stop_entry                   = 1'b1;
        end
      end
      MODE_STOP:
      begin
        if (!stop_req_in)
        begin
          state_next.mode = MODE_RUN;
          stop_exit       = 1'b1;
        end
      end
      default:
      begin
        state_next.mode = MODE_RUN;
      end
    endcase

    state_next.xtal_q = crystal_clock_in;
    state_next.vco_q  = vco_clock_in;
    state_next.lock_q = lock_in;
    xtal_rise         = crystal_clock_in && !state_reg.xtal_q;
    vco_rise          = vco_clock_in && !state_reg.vco_q;

    // Power enables
    state_next.osc_en  = osc_alive;
    state_next.loop_en = state_reg.loop_on && !in_stop;

    // Crystal clock passes only while the oscillator runs
    state_next.xtal_out = osc_alive && crystal_clock_in;

    // Bus clock is the selected source halved
    src_rise = state_reg.base_clock_select ? (vco_rise && state_reg.loop_on && !in_stop) : xtal_rise;
    if (!osc_alive)
    begin
      state_next.bus_clk = 1'b0;
    end
    else if (src_rise)
    begin
      state_next.bus_clk = !state_reg.bus_clk;
    end

    // Lock flag sets on any lock change in automatic mode
    lock_set = state_reg.auto_bw && (lock_in != state_reg.lock_q);

    // Break protection of the lock flag
    protect  = break_in && !state_reg.break_clear_enable;
    loop_rd  = rd_in && (addr_in == `CG_OFS_LOOP);
    lock_clr = loop_rd && !protect;

    // Loop interrupt, masked outside automatic mode and in full stop
    state_next.clockgen_irq = state_reg.auto_bw && state_reg.loop_irq_en && lock_flag
                              && osc_alive;

    ev_set                 = '0;
    ev_set[`CG_EV_STOP_IN]  = stop_entry;
    ev_set[`CG_EV_STOP_OUT] = stop_exit;
    ev_set[`CG_EV_LOCK]     = lock_set;
    ev_clr                 = '0;

    // Register writes
    if (wr_in)
    begin
      if (addr_in == `CG_OFS_LOOP)
      begin
        state_next.loop_irq_en = wdata_in[`CG_LOOP_IE_BIT];
        state_next.loop_on     = wdata_in[`CG_LOOP_ON_BIT];
        // Select may only be set while running; stop forces it clear
        if (!in_stop && !stop_req_in)
        begin
          state_next.base_clock_select = wdata_in[`CG_LOOP_BCS_BIT];
        end
      end
      else if (addr_in == `CG_OFS_BANDWIDTH)
      begin
        state_next.auto_bw = wdata_in[`CG_BW_AUTO_BIT];
      end
      else if (addr_in == `CG_OFS_BRK_CTRL)
      begin
        state_next.break_clear_enable = wdata_in[`CG_BRK_BREAK_CLEAR_ENABLE_BIT];
      end
      else if (addr_in == `CG_OFS_CONFIG)
      begin
        state_next.osc_run_in_stop = wdata_in[`CG_CFG_OSC_BIT];
      end
      else if (addr_in == `CG_OFS_IRQ_CLR)
      begin
        ev_clr = wdata_in[2:0];
      end
      else if (addr_in == `CG_OFS_IRQ_EN)
      begin
        state_next.irq_en = wdata_in[2:0];
      end
    end

    // Register reads
    if (rd_in)
    begin
      if (addr_in == `CG_OFS_LOOP)
      begin
        state_next.rdata[`CG_LOOP_IE_BIT]   = state_reg.loop_irq_en;
        state_next.rdata[`CG_LOOP_FLAG_BIT] = lock_flag && state_reg.auto_bw;
        state_next.rdata[`CG_LOOP_ON_BIT]   = state_reg.loop_on;
        state_next.rdata[`CG_LOOP_BCS_BIT]  = state_reg.base_clock_select;
      end
      else if (addr_in == `CG_OFS_BANDWIDTH)
      begin
        state_next.rdata[`CG_BW_AUTO_BIT] = state_reg.auto_bw;
        state_next.rdata[`CG_BW_LOCK_BIT] = state_reg.auto_bw && state_reg.lock_q;
      end
      else if (addr_in == `CG_OFS_BRK_CTRL)
      begin
        state_next.rdata[`CG_BRK_BREAK_CLEAR_ENABLE_BIT] = state_reg.break_clear_enable;
      end
      else if (addr_in == `CG_OFS_CONFIG)
      begin
        state_next.rdata[`CG_CFG_OSC_BIT] = state_reg.osc_run_in_stop;
      end
      else if (addr_in == `CG_OFS_IRQ_STAT)
      begin
        state_next.rdata[2:0] = ev_flags;
      end
      else if (addr_in == `CG_OFS_IRQ_EN)
      begin
        state_next.rdata[2:0] = state_reg.irq_en;
      end
    end

    state_next.irq = |(ev_flags & state_reg.irq_en);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg                    <= '0;
      state_reg.mode               <= MODE_RUN;
      state_reg.break_clear_enable <= `CG_RST_BREAK_CLEAR_ENABLE;
      state_reg.osc_run_in_stop    <= `CG_RST_OSC_RUN;
      state_reg.irq_en             <= `CG_RST_IRQ_EN;
      state_reg.osc_en             <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_out         = state_reg.rdata;
  assign crystal_clock_out = state_reg.xtal_out;
  assign bus_clock_out     = state_reg.bus_clk;
  assign clockgen_irq_out  = state_reg.clockgen_irq;
  assign osc_enable_out    = state_reg.osc_en;
  assign loop_enable_out   = state_reg.loop_en;
  assign irq_out           = state_reg.irq;

endmodule

// ### verif/stop_break_properties.sv
module stop_break_properties
  import clockgen_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       stop_req_in,
  input wire logic       break_in,
  input wire logic       lock_in,
  input wire logic       crystal_clock_in,
  input wire logic       vco_clock_in,
  input wire logic       crystal_clock_out,
  input wire logic       bus_clock_out,
  input wire logic       clockgen_irq_out,
  input wire logic       osc_enable_out,
  input wire logic       loop_enable_out,
  input wire logic       irq_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic osc_q;
  logic auto_q;
  logic break_clear_enable_q;

  // Shadow copies of the control bits seen on the register port
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      osc_q  <= 1'b0;
      auto_q <= 1'b0;
      break_clear_enable_q <= 1'b0;
    end
    else if (wr_in)
    begin
      if (addr_in == 3'h3)
        osc_q <= wdata_in[1];
      if (addr_in == 3'h1)
        auto_q <= wdata_in[7];
      if (addr_in == 3'h2)
        break_clear_enable_q <= wdata_in[7];
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence rd_loop;
    rd_in && addr_in == 3'h0;
  endsequence
  sequence stop_held;
    stop_req_in [*2];
  endsequence

  chk_stop_loop_off: assert property (stop_held |=> !loop_enable_out)
    else $error("loop stays powered in stop");
  chk_stop_gates_out: assert property ((stop_req_in && !osc_q) ##1 stop_req_in
    |=> !osc_enable_out && !crystal_clock_out && !bus_clock_out && !clockgen_irq_out)
    else $error("outputs not held low in stop");
  chk_osc_keeps_run: assert property ((stop_req_in && osc_q) ##1 stop_req_in |=> osc_enable_out)
    else $error("oscillator stopped despite run option");
  chk_bcs_clear_stop: assert property (stop_req_in ##1 rd_loop |=> !rdata_out[4])
    else $error("base select still set after stop");
  chk_lock_sets: assert property ((auto_q && $changed(lock_in) && !rd_in && !wr_in)
    ##1 (!rd_in && !wr_in) [*2] ##1 rd_loop |=> rdata_out[6])
    else $error("lock change not flagged");
  chk_break_keeps: assert property ((auto_q && break_in && !break_clear_enable_q) ##0 rd_loop
    ##1 (rd_loop and rdata_out[6]) |=> rdata_out[6])
    else $error("lock flag cleared in protected break");
  chk_break_clears: assert property ((auto_q && break_in && break_clear_enable_q && !$changed(lock_in)) ##0 rd_loop
    ##1 rd_loop |=> !rdata_out[6])
    else $error("lock flag not cleared in break");
  chk_auto_off_flag: assert property (!auto_q ##0 rd_loop |=> !rdata_out[6])
    else $error("lock flag visible with auto off");
  chk_auto_off_irq: assert property (!auto_q |=> !clockgen_irq_out)
    else $error("loop interrupt with auto off");
endmodule

bind clockgen_stop_break_control stop_break_properties props (
  .sys_clk_in        (sys_clk_in),
  .sys_rst_in        (sys_rst_in),
  .addr_in           (addr_in),
  .wdata_in          (wdata_in),
  .wr_in             (wr_in),
  .rd_in             (rd_in),
  .rdata_out         (rdata_out),
  .stop_req_in       (stop_req_in),
  .break_in          (break_in),
  .lock_in           (lock_in),
  .crystal_clock_in  (crystal_clock_in),
  .vco_clock_in      (vco_clock_in),
  .crystal_clock_out (crystal_clock_out),
  .bus_clock_out     (bus_clock_out),
  .clockgen_irq_out  (clockgen_irq_out),
  .osc_enable_out    (osc_enable_out),
  .loop_enable_out   (loop_enable_out),
  .irq_out           (irq_out)
);

// ### verif/core_side_model.sv
module core_side_model (
  input  wire logic sys_clk_in,          // System clock
  input  wire logic stop_cmd_in,         // Bench stop command
  input  wire logic brk_cmd_in,          // Bench break command
  input  wire logic lock_cmd_in,         // Bench lock level
  input  wire logic osc_en_in,           // Oscillator power
  input  wire logic loop_en_in,          // Loop power
  output logic      stop_req_out = 1'b0, // Stop request
  output logic      break_out    = 1'b0, // Break state
  output logic      lock_out     = 1'b0, // Lock indicator
  output logic      xtal_out     = 1'b0, // Oscillator level
  output logic      vco_out      = 1'b0  // VCO level
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge sys_clk_in)
  begin
    stop_req_out <= stop_cmd_in;
    break_out    <= brk_cmd_in;
    lock_out     <= lock_cmd_in;
    // A powered-down source sits low; an unknown enable counts as off
    xtal_out     <= (osc_en_in === 1'b1) && !xtal_out;
    vco_out      <= (loop_en_in === 1'b1) && !vco_out;
  end
endmodule

// ### verif/clockgen_stop_break_control_tb.sv
module clockgen_stop_break_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [2:0]  addr_in    = 3'h0;
  logic [7:0]  wdata_in   = 8'h00;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [7:0]  rdata_out;
  logic        stop_req_in, break_in, lock_in, crystal_clock_in, vco_clock_in;
  logic        crystal_clock_out, bus_clock_out, clockgen_irq_out, osc_enable_out, loop_enable_out, irq_out;
  logic        stop_cmd = 1'b0, brk_cmd = 1'b0, lock_cmd = 1'b0, rd_d = 1'b0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'h000125D1;
  int          errors = 0, comparisons = 0, i;

  always #4 sys_clk_in = ~sys_clk_in;

  clockgen_stop_break_control uut (
    .sys_clk_in        (sys_clk_in),
    .sys_rst_in        (sys_rst_in),
    .addr_in           (addr_in),
    .wdata_in          (wdata_in),
    .wr_in             (wr_in),
    .rd_in             (rd_in),
    .rdata_out         (rdata_out),
    .stop_req_in       (stop_req_in),
    .break_in          (break_in),
    .lock_in           (lock_in),
    .crystal_clock_in  (crystal_clock_in),
    .vco_clock_in      (vco_clock_in),
    .crystal_clock_out (crystal_clock_out),
    .bus_clock_out     (bus_clock_out),
    .clockgen_irq_out  (clockgen_irq_out),
    .osc_enable_out    (osc_enable_out),
    .loop_enable_out   (loop_enable_out),
    .irq_out           (irq_out)
  );
  core_side_model far (.sys_clk_in(sys_clk_in), .stop_cmd_in(stop_cmd), .brk_cmd_in(brk_cmd),
    .lock_cmd_in(lock_cmd), .osc_en_in(osc_enable_out), .loop_en_in(loop_enable_out),
    .stop_req_out(stop_req_in), .break_out(break_in), .lock_out(lock_in),
    .xtal_out(crystal_clock_in), .vco_out(vco_clock_in));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task finish_test();
    $display("Totals: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task idle(input int n, input string name);
    rd_in <= 1'b0;
    wr_in <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    if (name != "")
      $display("finished: %s", name);
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    rd_in    <= 1'b0;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
  endtask

  task rd(input logic [2:0] a, input logic [7:0] e);
    addr_in <= a;
    wr_in   <= 1'b0;
    rd_in   <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_in);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_in)
  begin
    if (rd_d)
      check(rdata_out, exp_q.pop_front());
    rd_d <= rd_in;
  end

  // All scenarios; a timeout returns early to the closing report
  task automatic run_all();
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(3'h2, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'hA0);
    lock_cmd <= 1'b1;
    idle(4, "reset and lock");
    check(8'(clockgen_irq_out), 8'h01);
    rd(3'h0, 8'hE0);
    rd(3'h0, 8'hA0);
    lock_cmd <= 1'b0;
    brk_cmd  <= 1'b1;
    idle(4, "");
    rd(3'h0, 8'hE0);
    rd(3'h0, 8'hE0);
    wr(3'h2, 8'h80);
    rd(3'h0, 8'hE0);
    rd(3'h0, 8'hA0);
    brk_cmd <= 1'b0;
    idle(3, "");
    rd(3'h0, 8'hA0);
    lock_cmd <= 1'b1;
    idle(4, "break");
    wr(3'h1, 8'h00);
    idle(2, "");
    check(8'(clockgen_irq_out), 8'h00);
    rd(3'h0, 8'hA0);
    rd(3'h1, 8'h00);
    wr(3'h5, 8'h07);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h30);
    stop_cmd <= 1'b1;
    idle(6, "auto off");
    check({3'h0, loop_enable_out, osc_enable_out, crystal_clock_out, bus_clock_out, clockgen_irq_out}, 8'h00);
    check(8'(irq_out), 8'h01);
    rd(3'h0, 8'h20);
    wr(3'h6, 8'h00);
    idle(2, "");
    check(8'(irq_out), 8'h00);
    wr(3'h6, 8'h01);
    idle(2, "");
    check(8'(irq_out), 8'h01);
    wr(3'h5, 8'h01);
    wr(3'h0, 8'h30);
    stop_cmd <= 1'b0;
    idle(3, "");
    check(8'(irq_out), 8'h00);
    for (i = 0; i < 20 && bus_clock_out !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (bus_clock_out !== 1'b1)
    begin
      errors++;
      return;
    end
    rd(3'h4, 8'h02);
    rd(3'h0, 8'h20);
    wr(3'h3, 8'h02);
    stop_cmd <= 1'b1;
    idle(6, "stop");
    check({6'h00, osc_enable_out, loop_enable_out}, 8'h02);
    stop_cmd <= 1'b0;
    idle(4, "stop with oscillator");
    wr(3'h0, 8'h30);
    rd(3'h0, 8'h30);
    repeat (4)
    begin
      seed = xorshift(seed);
      wr(3'h6, seed[7:0]);
      rd(3'h6, {5'h00, seed[2:0]});
    end
    idle(3, "random enables");
  endtask

  initial
  begin
    run_all();
    finish_test();
  end
endmodule
